// File: sarc_ctrl.sv
// Successive-approximation register controller, top level.
// Assumes COMP_HI is synchronous to CLK and settled before step end.
module sarc_ctrl
    import sarc_pkg::*;
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic COMP_HI,
    output logic [SARC_WIDTH-1:0] DAC_CODE,
    output logic [SARC_WIDTH-1:0] RESULT,
    output logic SER_BIT,
    output logic SER_VALID,
    output logic CONV_DONE,
    output logic CONV_BUSY
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    // Sequencer state and its next value
    sarc_state_type state_r; // Current sequencer state
    sarc_state_type state_nxt; // Next sequencer state
    // Trial code presented to the feedback converter
    logic [SARC_WIDTH-1:0] code_r; // Kept bits plus bit under test
    logic [SARC_WIDTH-1:0] code_nxt; // Next trial code
    // Position of the bit under test, MSB first
    logic [SARC_IDX_W-1:0] idx_r; // Bit under test
    logic [SARC_IDX_W-1:0] idx_nxt; // Next bit under test
    // Parallel result, valid between conversions
    logic [SARC_WIDTH-1:0] result_r; // Last finished code
    logic [SARC_WIDTH-1:0] result_nxt; // Next finished code
    // Serial output, one decision per step
    logic ser_r; // Decision of the last step
    logic ser_nxt; // Next decision bit
    logic serv_r; // Strobe: a decision was just made
    logic serv_nxt; // Next strobe
    // Completion and activity flags
    logic done_r; // One-cycle pulse after the LSB
    logic done_nxt; // Next completion pulse
    logic busy_r; // Converting, registered for the pin
    logic busy_nxt; // Next activity flag
    // ----------------------------------------
    // Internal strobes and decodes
    // ----------------------------------------
    logic start; // Launch of a conversion
    logic step_end; // Last cycle of a trial
    logic [SARC_WIDTH-1:0] bit_sel; // One-hot of bit under test
    logic [SARC_WIDTH-1:0] next_sel; // One-hot of next lower bit
    logic [SARC_WIDTH-1:0] decided; // Trial code after this step's decision

    // ----------------------------------------
    // Step timer
    // ----------------------------------------
    sarc_step_timer u_timer (
        .clk(CLK),
        .rst_b(RST_B),
        .restart(start),
        .step_end(step_end)
    );

    // ----------------------------------------
    // Bit decode
    // ----------------------------------------
    // One-hot decode, scales with width
    genvar gi;
    generate
        for (gi = 0; gi < SARC_WIDTH; gi++) begin : g_sel
            // This bit is the one under test
            assign bit_sel[gi] = (idx_r == SARC_IDX_W'(gi));
            if (gi < SARC_WIDTH - 1) begin : g_below
                // This bit is the next one down
                assign next_sel[gi] = (idx_r == SARC_IDX_W'(gi + 1));
            end else begin : g_top
                // Nothing lies above the MSB; a wrapped compare would alias the LSB
                assign next_sel[gi] = 1'b0;
            end
        end
    endgenerate

    // Keep the tested bit on high, clear it on low
    assign decided = COMP_HI ? code_r : (code_r & ~bit_sel);

    // Start only leaving reset; later conversions chain directly.
    // Reset is the only way back to idle, so a stuck comparator
    // cannot stall the sequencer: steps run on time regardless.
    assign start = (state_r == SARC_IDLE);

    // ----------------------------------------
    // Next-state logic
    // ----------------------------------------
    // Computes every next value; the register process only stores them
    always_comb begin
        // Hold by default; strobes fall back to zero
        state_nxt = state_r;
        code_nxt = code_r;
        idx_nxt = idx_r;
        result_nxt = result_r;
        ser_nxt = ser_r;
        serv_nxt = 1'b0;
        done_nxt = 1'b0;
        case (state_r)
            SARC_IDLE: begin
                // Only MSB set for first trial, half scale
                code_nxt = SARC_CODE_ZERO;
                code_nxt[SARC_MSB_IDX] = 1'b1;
                idx_nxt = SARC_MSB_IDX;
                state_nxt = SARC_CONV;
            end
            SARC_CONV: begin
                if (step_end) begin
                    // Comparator is read once, at the end of the step
                    code_nxt = decided; // Keep on high, clear on low
                    ser_nxt = COMP_HI; // Decision is serial bit
                    serv_nxt = 1'b1;
                    if (idx_r == SARC_LSB_IDX) begin
                        // LSB decided: latch result, restart
                        result_nxt = decided;
                        done_nxt = 1'b1;
                        code_nxt = SARC_CODE_ZERO;
                        code_nxt[SARC_MSB_IDX] = 1'b1; // Half scale again
                        idx_nxt = SARC_MSB_IDX;
                    end else begin
                        // Add next lower bit, lower bits stay clear
                        code_nxt = decided | next_sel;
                        idx_nxt = idx_r - SARC_IDX_W'(1);
                    end
                end else begin
                    // Mid-step: the DAC settles, nothing moves
                    code_nxt = code_r;
                end
            end
            default: begin
                state_nxt = SARC_IDLE; // Recover from illegal code
            end
        endcase
        // Pin shows converting from the first edge after reset
        busy_nxt = (state_nxt == SARC_CONV);
    end

    // Registers only store; the async reset loads constants
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            state_r <= SARC_IDLE;
            code_r <= SARC_CODE_ZERO;
            idx_r <= SARC_MSB_IDX;
            result_r <= SARC_CODE_ZERO;
            ser_r <= 1'b0;
            serv_r <= 1'b0;
            done_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            idx_r <= idx_nxt;
            result_r <= result_nxt;
            ser_r <= ser_nxt;
            serv_r <= serv_nxt;
            done_r <= done_nxt;
            busy_r <= busy_nxt;
        end
    end

    // ----------------------------------------
    // Outputs straight from flip-flops
    // ----------------------------------------
    assign DAC_CODE = code_r;
    assign RESULT = result_r;
    assign SER_BIT = ser_r;
    assign SER_VALID = serv_r;
    assign CONV_DONE = done_r;
    assign CONV_BUSY = busy_r; // Registered so the pin carries no decode glitch

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    // Lower bits below the test bit are clear
    low_clear_a: assert property (@(posedge CLK) disable iff (!RST_B)
        state_r == SARC_CONV |-> ((code_r & (bit_sel - SARC_WIDTH'(1))) == SARC_CODE_ZERO))
        else $error("bits below test bit not clear");
    test_bit_set_a: assert property (@(posedge CLK) disable iff (!RST_B)
        state_r == SARC_CONV |-> (code_r & bit_sel) != SARC_CODE_ZERO)
        else $error("bit under test not set");
    clear_on_low_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (step_end && !COMP_HI && idx_r != SARC_LSB_IDX) |=>
        (code_r & $past(bit_sel)) == SARC_CODE_ZERO)
        else $error("tested bit not cleared on low");
    keep_on_high_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (step_end && COMP_HI && idx_r != SARC_LSB_IDX) |=>
        (code_r & $past(bit_sel)) != SARC_CODE_ZERO)
        else $error("tested bit lost on high");
    msb_start_a: assert property (@(posedge CLK) disable iff (!RST_B)
        done_r |-> code_r == (SARC_WIDTH'(1) << SARC_MSB_IDX))
        else $error("new conversion not at half scale");
    idx_step_a: assert property (@(posedge CLK) disable iff (!RST_B)
        (step_end && idx_r != SARC_LSB_IDX) |=> idx_r == $past(idx_r) - SARC_IDX_W'(1))
        else $error("bit index did not step down");
    result_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        !done_r |-> $stable(result_r) or $past(state_r) == SARC_IDLE)
        else $error("result changed outside completion");
    serial_bit_a: assert property (@(posedge CLK) disable iff (!RST_B)
        step_end |=> serv_r && ser_r == $past(COMP_HI))
        else $error("serial bit not the decision");
    done_pulse_a: assert property (@(posedge CLK) disable iff (!RST_B)
        done_r |=> !done_r && CONV_BUSY)
        else $error("done not a single pulse");
    // Once started, the sequencer never leaves conversion
    busy_hold_a: assert property (@(posedge CLK) disable iff (!RST_B)
        busy_r |=> busy_r)
        else $error("conversion stopped");
    // A decision strobe only follows the last cycle of a step
    strobe_src_a: assert property (@(posedge CLK) disable iff (!RST_B)
        serv_r |-> $past(step_end))
        else $error("decision strobe outside step end");
    // Steps are far apart: no strobe within eight cycles of another
    step_gap_a: assert property (@(posedge CLK) disable iff (!RST_B)
        serv_r |=> (!serv_r) [*8])
        else $error("trial step too short");
    // Completion comes with the LSB decision
    done_lsb_a: assert property (@(posedge CLK) disable iff (!RST_B)
        done_r |-> serv_r && $past(idx_r) == SARC_LSB_IDX)
        else $error("done without LSB decision");
    // Result is the kept bits plus the LSB decision
    result_load_a: assert property (@(posedge CLK) disable iff (!RST_B)
        done_r |-> result_r[SARC_WIDTH-1:1] == $past(code_r[SARC_WIDTH-1:1])
            && result_r[0] == $past(COMP_HI))
        else $error("result not the decided code");
endmodule // sarc_ctrl

// File: sarc_pkg.sv
// Constants and types for the successive-approximation controller.
// Assumes a single 100 MHz clock and an external comparator and DAC.
// Function
// - Test one code bit per step, MSB first
// - Conversion starts with only MSB set
// - Trial code: kept bits plus test bit
// - Comparator low clears the tested bit
// - Comparator high keeps the tested bit
// - Repeat steps down to the LSB
// - Restart conversion immediately after completion
// - Final code held as parallel result
// - Serial output is each decision, MSB first
// - Word width is a scalable parameter
// - Step lasts long enough for settling
package sarc_pkg;
    // ----------------------------------------
    // Sizes and timing
    // ----------------------------------------
    localparam int SARC_WIDTH = 8; // Converter word width
    localparam int SARC_CLK_MHZ = 100; // Clock rate
    localparam int SARC_STEP_NS = 200; // Least time per bit trial
    // Cycles per step, rounded up
    localparam int SARC_STEP_CYC = (SARC_STEP_NS * SARC_CLK_MHZ + 999) / 1000;
    localparam int SARC_CNT_W = $clog2(SARC_STEP_CYC + 1);
    localparam int SARC_IDX_W = $clog2(SARC_WIDTH);
    localparam logic [SARC_IDX_W-1:0] SARC_MSB_IDX = SARC_IDX_W'(SARC_WIDTH - 1);
    localparam logic [SARC_IDX_W-1:0] SARC_LSB_IDX = SARC_IDX_W'(0);
    localparam logic [SARC_CNT_W-1:0] SARC_CNT_LAST = SARC_CNT_W'(SARC_STEP_CYC - 1);
    localparam logic [SARC_CNT_W-1:0] SARC_CNT_ZERO = SARC_CNT_W'(0);
    localparam logic [SARC_WIDTH-1:0] SARC_CODE_ZERO = SARC_WIDTH'(0);

    // ----------------------------------------
    // Sequencer states
    // ----------------------------------------
    typedef enum logic [0:0] {
        SARC_IDLE = 1'b0, // Out of reset, before first conversion
        SARC_CONV = 1'b1 // Converting
    } sarc_state_type;
endpackage

// File: sarc_step_timer.sv
// Step timer: counts the cycles of one bit trial.
// Assumes restart is a one-cycle pulse from the sequencer.
module sarc_step_timer
    import sarc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic restart,
    output logic step_end
);
    logic [SARC_CNT_W-1:0] cnt_r; // Cycle count within step
    logic [SARC_CNT_W-1:0] cnt_nxt;

    // ----------------------------------------
    // Next count
    // ----------------------------------------
    always_comb begin
        if (restart || cnt_r == SARC_CNT_LAST) begin
            cnt_nxt = SARC_CNT_ZERO; // New step begins
        end else begin
            cnt_nxt = cnt_r + SARC_CNT_W'(1);
        end
    end

    // Counter register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_r <= SARC_CNT_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    // Last cycle of step: comparator is sampled here only
    assign step_end = (cnt_r == SARC_CNT_LAST) && !restart;
endmodule // sarc_step_timer

// File: sarc_comp_model.sv
// Partner model: analog comparator plus feedback DAC of the converter.
// Assumes the bench holds the analog input steady through a conversion.
module sarc_comp_model
    import sarc_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [SARC_WIDTH-1:0] dac_code,
    input wire logic [SARC_WIDTH-1:0] vin,
    output logic comp_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SARC_WIDTH-1:0] code_r; // Code seen last cycle
    int settle_r; // Cycles since the code last moved
    // ----------------------------------------
    // Comparator with settling
    // ----------------------------------------
    // Answers wrongly while the DAC settles, so early sampling is caught
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            code_r <= '0;
            settle_r <= 0;
            comp_hi <= 1'b0;
        end else begin
            code_r <= dac_code;
            settle_r <= (dac_code != code_r) ? 0 : settle_r + 1;
            // High when input at or above DAC level
            comp_hi <= (settle_r < 4) ^ (vin >= dac_code);
        end
    end
endmodule // sarc_comp_model

// File: tb_top.sv
// Self-checking bench for the successive-approximation controller.
// Assumes the package width and step length; partner model closes the loop.
module tb_top
    import sarc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // Room for reset and twelve conversions, plus slack
    localparam int CYCLE_LIMIT = 16 + 12 * SARC_WIDTH * SARC_STEP_CYC + 500;
    logic CLK, RST_B, COMP_HI, SER_BIT, SER_VALID, CONV_DONE, CONV_BUSY;
    logic [SARC_WIDTH-1:0] DAC_CODE, RESULT, vin, vin_next, vin_cur, kept;
    int errors = 0, checks = 0, cycles = 0, idx = SARC_WIDTH - 1, cyc = 0, nconv = 0;
    bit [31:0] seed = 32'h41; // Xorshift state, starts at 65
    logic dec;
    logic ser_q[$]; // Serial bits of the running conversion
    logic [SARC_WIDTH-1:0] ser_word; // Serial bits packed MSB first
    sarc_ctrl dut (.CLK(CLK), .RST_B(RST_B), .COMP_HI(COMP_HI), .DAC_CODE(DAC_CODE),
        .RESULT(RESULT), .SER_BIT(SER_BIT), .SER_VALID(SER_VALID),
        .CONV_DONE(CONV_DONE), .CONV_BUSY(CONV_BUSY));
    sarc_comp_model peer (.clk(CLK), .rst_b(RST_B), .dac_code(DAC_CODE), .vin(vin),
        .comp_hi(COMP_HI));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic bit [31:0] xs(input bit [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [SARC_WIDTH-1:0] seen, exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, input stimulus, timeout
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #5 CLK = ~CLK;
    end
    // New input only after a done pulse; extremes first, then random
    always @(posedge CLK) begin
        cycles++;
        if (CONV_DONE === 1'b1) begin
            vin <= vin_next;
            seed = xs(seed);
            vin_next = (nconv == 1) ? 8'h00 : seed[SARC_WIDTH-1:0];
        end
    end
    // ----------------------------------------
    // Reference model, checked every cycle
    // ----------------------------------------
    always @(negedge CLK) begin
        if (RST_B && CONV_BUSY === 1'b1) begin
            if (SER_VALID === 1'b1) begin
                check(8'(cyc), 8'(SARC_STEP_CYC), "step length");
                cyc = 0;
                dec = ((kept | (8'h01 << idx)) <= vin_cur);
                check(8'(SER_BIT), 8'(dec), "serial bit");
                ser_q.push_back(SER_BIT);
                if (dec) kept = kept | (8'h01 << idx);
                check(8'(CONV_DONE), 8'(idx == 0), "done pulse");
                if (idx == 0) begin
                    check(RESULT, kept, "parallel result");
                    check(RESULT, vin_cur, "converted value");
                    check(8'(ser_q.size()), 8'(SARC_WIDTH), "serial bit count");
                    ser_word = 8'h00;
                    while (ser_q.size() > 0) begin
                        ser_word = {ser_word[SARC_WIDTH-2:0], ser_q.pop_front()};
                    end
                    check(ser_word, vin_cur, "serial word");
                    kept = 8'h00;
                    idx = SARC_WIDTH - 1;
                    vin_cur = vin_next;
                    nconv++;
                end else idx--;
            end else check(8'(CONV_DONE), 8'h00, "stray done");
            cyc++;
            // Kept bits, one test bit, lower bits clear
            check(DAC_CODE, kept | (8'h01 << idx), "trial code");
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        RST_B = 1'b0;
        kept = 8'h00;
        vin = 8'hFF;
        vin_next = 8'hFF;
        vin_cur = 8'hFF;
        repeat (16) @(posedge CLK);
        check(DAC_CODE, 8'h00, "code in reset");
        check(8'(CONV_BUSY), 8'h00, "busy in reset");
        RST_B <= 1'b1;
        // First edge after release starts the first trial
        @(posedge CLK);
        @(negedge CLK);
        check(8'(CONV_BUSY), 8'h01, "busy after reset");
        check(DAC_CODE, 8'h80, "half scale first");
        wait (nconv == 12 || cycles >= CYCLE_LIMIT);
        // A run that times out counts as a mismatch
        if (nconv < 12) begin
            errors++;
        end
        report_and_stop();
    end
endmodule // tb_top
